// ---- inc/nes_defs.svh ----
// Offsets, field positions, reset values and timing counts for event status
`ifndef NES_DEFS_SVH
`define NES_DEFS_SVH
// Byte addresses on the host bus
`define NES_ADDR_TIME_LO 8'h10
`define NES_ADDR_TIME_HI 8'h11
`define NES_ADDR_EVT_LO 8'h12
`define NES_ADDR_EVT_HI 8'h13
// Event status bit positions
`define EVT_RX_ERR 15
`define EVT_DEC_FIX 14
`define EVT_UNLOCK 13
`define EVT_WARN 12
`define EVT_FREE_RX 11
`define EVT_REMOTE_RX 10
`define EVT_OWN_RX 9
`define EVT_SRC_MATCH 8
`define EVT_TKN_RETRY 7
`define EVT_REPLY_FIX 6
`define EVT_HUB_WDT 5
`define EVT_BAD_PTR 4
`define EVT_CORE 3
`define EVT_NO_REPLY 2
`define EVT_TX_ERR 1
`define EVT_TX_AVAIL 0
// Bits that are write-one-to-clear
`define EVT_RW_MASK 16'hcff6
// Send and no-reply flags cleared by a send command
`define EVT_SEND_CLR 16'h0006
// Reset values
`define TIME_RESET 16'h0000
`define DETAIL_RESET 16'h0000
// Command codes
`define CMD_SEND 8'h03
`define CMD_WARN_CLR 8'h0a
// Lowest legal page pointer is above this
`define PTR_LOW_BAD 8'h02
// Timing: clock rate and hub watchdog times in nanoseconds
`define CLK_MHZ 250
`define HUB_WDT_SLOW_NS 3270000
`define HUB_WDT_FAST_NS 1640000
`define HUB_WDT_SLOW_CYC ((`HUB_WDT_SLOW_NS * `CLK_MHZ + 999) / 1000)
`define HUB_WDT_FAST_CYC ((`HUB_WDT_FAST_NS * `CLK_MHZ + 999) / 1000)
// Remote receive warning period, in cycles (plain default)
`define WARN_PERIOD_CYC 1000000
`endif

// ---- inc/nes_pkg.sv ----
// Types shared by the event status block and its hub watchdog
package nes_pkg;
    typedef enum logic [1:0] {
        NES_WD_IDLE = 2'b00,
        NES_WD_COUNT = 2'b01,
        NES_WD_HOLD = 2'b10
    } nes_wd_state_t;

    typedef struct packed {
        nes_wd_state_t st;
        logic [19:0] cnt;
        logic trip;
        logic hubRst;
        logic decRst;
    } nes_wd_t;

    typedef struct packed {
        logic [15:0] netTime;
        logic [7:0] timeHold;
        logic [15:0] flags;
        logic unlocked;
        logic warnFlag;
        logic [31:0] warnCnt;
        logic coreIrq;
        logic txAvail;
        logic [15:0] detail;
        logic [15:0] rdData;
        logic irq;
        logic pageClr;
    } nes_state_t;
endpackage

// ---- hw/nes_hub_watchdog.sv ----
// Hub transmit watchdog: trips on a stuck transmit line, resets hub units
`timescale 1ns/10ps
`include "nes_defs.svh"
module nes_hub_watchdog
    import nes_pkg::*;
#(
    parameter int SLOW_CYC = `HUB_WDT_SLOW_CYC,
    parameter int FAST_CYC = `HUB_WDT_FAST_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hubTxActive,
    input wire logic hubEnabled,
    input wire logic rate5M,
    output logic trip,
    output logic hubRst,
    output logic decRst
);
    nes_wd_t s, n; // State and its next value
    logic [19:0] limit; // Cycles of continuous activity to trip

    // Limit halves at the faster line rate
    assign limit = rate5M ? 20'(FAST_CYC) : 20'(SLOW_CYC);

    // Count continuous activity; one pulse per trip, then wait for release
    always_comb begin
        n = s;
        n.trip = 1'b0;
        n.hubRst = 1'b0;
        n.decRst = 1'b0;
        case (s.st)
            NES_WD_IDLE: begin
                n.cnt = 20'h00001;
                if (hubTxActive) begin
                    n.st = NES_WD_COUNT;
                end
            end
            NES_WD_COUNT: begin
                if (!hubTxActive) begin
                    n.st = NES_WD_IDLE;
                end else if (s.cnt >= limit - 20'h00001) begin
                    // Stuck line: reset hub; decoders only if hub is on
                    n.trip = 1'b1;
                    n.hubRst = 1'b1;
                    n.decRst = hubEnabled;
                    n.st = NES_WD_HOLD;
                end else begin
                    n.cnt = s.cnt + 20'h00001;
                end
            end
            NES_WD_HOLD: begin
                // Avoids retriggering before the reset hub drops its line
                if (!hubTxActive) begin
                    n.st = NES_WD_IDLE;
                end
            end
            default: begin
                n.st = NES_WD_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s <= '{NES_WD_IDLE, 20'h00000, 1'b0, 1'b0, 1'b0};
        end else begin
            s <= n;
        end
    end

    assign trip = s.trip;
    assign hubRst = s.hubRst;
    assign decRst = s.decRst;

    AST_WD_DEC_GATE: assert property (
        @(posedge sys_clk) disable iff (rst)
        decRst |-> $past(hubEnabled) && hubRst)
        else $error("decoder reset while hub off");
    AST_WD_ONE_PULSE: assert property (
        @(posedge sys_clk) disable iff (rst) trip |=> !trip)
        else $error("watchdog trip longer than one cycle");
endmodule

// ---- hw/network_event_status.sv ----
// Network time counter and event status register of the network controller
//
// Overview of operation
// - Read-only 16-bit time counter, resets to zero
// - Low byte read latches the high byte
// - Upper byte receive flags, lower transmit flags
// - Packet receive error sets bit 15, detail
// - Only data packet errors set bit 15
// - Writable flags clear on one, soft reset
// - Decoder correction sets bit 14 with detail
// - Bit 13 unlock flag, master node reads zero
// - Bit 12 warning timeout, cleared by command
// - Free-format and remote page completions, bits 11,10
// - Own packet received sets bit 9
// - Source ID match sets bit 8
// - Token retry bit 7, reply repair bit 6
// - Hub transmit stuck timeout sets bit 5
// - Watchdog resets hub and decoders if on
// - Invalid sent page pointer sets bit 4
// - Bit 3 reports core interrupt
// - No enquiry reply sets bits 2 and 1
// - Send command clears transmit error flags
// - Bit 0 mirrors transmitter available, resets 1
// - Three transmit bits encode transmit outcome
// - Interrupt when flag and mask both set
// - Warning clear command clears status, restarts timer
`timescale 1ns/10ps
`include "nes_defs.svh"
module network_event_status
    import nes_pkg::*;
#(
    parameter int HUB_SLOW_CYC = `HUB_WDT_SLOW_CYC,
    parameter int HUB_FAST_CYC = `HUB_WDT_FAST_CYC,
    parameter int WARN_CYC = `WARN_PERIOD_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic softReset,
    // Host bus
    input wire logic wideBus,
    input wire logic [7:0] busAddr,
    input wire logic busRd,
    input wire logic busWr,
    input wire logic [15:0] busWrData,
    // Commands and mask from neighbouring registers
    input wire logic cmdValid,
    input wire logic [7:0] cmdCode,
    input wire logic [15:0] eventMask,
    input wire logic [4:0] sourceIdSelect,
    // Time base
    input wire logic timeTick,
    input wire logic syncLock,
    input wire logic syncLost,
    input wire logic timeMasterNode,
    // Receive events
    input wire logic rxAbort,
    input wire logic rxIsPacket,
    input wire logic [2:0] rxErrCode,
    input wire logic [4:0] rxSenderId,
    input wire logic decodeCorrected,
    input wire logic [3:0] decodeInfo,
    input wire logic remotePagesActive,
    input wire logic remoteRxData,
    input wire logic freeformDone,
    input wire logic remoteDone,
    input wire logic ownDone,
    input wire logic rxSrcValid,
    input wire logic [4:0] rxSrcId,
    // Transmit events
    input wire logic tokenRetry,
    input wire logic replyRepair,
    input wire logic hubTxActive,
    input wire logic hubEnabled,
    input wire logic rate5M,
    input wire logic txPtrValid,
    input wire logic [7:0] txPagePointer,
    input wire logic [7:0] pageLimit,
    input wire logic coreInterrupt,
    input wire logic bufferQueryNoReply,
    input wire logic txFailed,
    input wire logic transmitterAvailable,
    // Outputs
    output logic [15:0] busRdData,
    output logic irq,
    output logic [15:0] errorDetail,
    output logic remotePageClr,
    output logic hubReset,
    output logic decoderReset
);
    nes_state_t s, n; // State and its next value
    logic wdTrip; // One-cycle hub watchdog timeout
    logic [15:0] setVec; // Hardware set requests this cycle
    logic [15:0] clrVec; // Clear requests this cycle
    logic [15:0] statusNow; // Status word as the host sees it
    logic cmdSend; // Send command issued
    logic cmdWarnClr; // Warning-clear command issued
    logic wrEvtLo; // Write strikes the low status byte
    logic wrEvtHi; // Write strikes the high status byte
    logic [15:0] wrOnes; // Ones written into the status word

    // Hub watchdog lives in its own module
    nes_hub_watchdog #(
        .SLOW_CYC(HUB_SLOW_CYC),
        .FAST_CYC(HUB_FAST_CYC)
    ) u_wdt (
        .sys_clk(sys_clk),
        .rst(rst),
        .hubTxActive(hubTxActive),
        .hubEnabled(hubEnabled),
        .rate5M(rate5M),
        .trip(wdTrip),
        .hubRst(hubReset),
        .decRst(decoderReset)
    );

    // Assemble the visible word from stored and read-only bits
    function automatic logic [15:0] status_word(input nes_state_t v);
        logic [15:0] w;
        w = v.flags & `EVT_RW_MASK;
        w[`EVT_UNLOCK] = v.unlocked;
        w[`EVT_WARN] = v.warnFlag;
        w[`EVT_CORE] = v.coreIrq;
        w[`EVT_TX_AVAIL] = v.txAvail;
        return w;
    endfunction

    assign statusNow = status_word(s);
    assign cmdSend = cmdValid && (cmdCode == `CMD_SEND);
    assign cmdWarnClr = cmdValid && (cmdCode == `CMD_WARN_CLR);

    // Byte lane decode: 16-bit hosts write the word at the even address
    assign wrEvtLo = busWr && (busAddr == `NES_ADDR_EVT_LO);
    assign wrEvtHi = busWr && !wideBus && (busAddr == `NES_ADDR_EVT_HI);
    always_comb begin
        wrOnes = 16'h0000;
        if (wrEvtLo && wideBus) begin
            wrOnes = busWrData;
        end else if (wrEvtLo) begin
            wrOnes = {8'h00, busWrData[7:0]};
        end else if (wrEvtHi) begin
            wrOnes = {busWrData[7:0], 8'h00};
        end
    end

    // Hardware events that set flags
    always_comb begin
        setVec = 16'h0000;
        setVec[`EVT_RX_ERR] = rxAbort && rxIsPacket;
        setVec[`EVT_DEC_FIX] = decodeCorrected;
        setVec[`EVT_FREE_RX] = freeformDone;
        setVec[`EVT_REMOTE_RX] = remoteDone;
        setVec[`EVT_OWN_RX] = ownDone;
        setVec[`EVT_SRC_MATCH] = rxSrcValid
            && (rxSrcId == sourceIdSelect);
        setVec[`EVT_TKN_RETRY] = tokenRetry;
        setVec[`EVT_REPLY_FIX] = replyRepair;
        setVec[`EVT_HUB_WDT] = wdTrip;
        // Pointer too low or past the page end
        setVec[`EVT_BAD_PTR] = txPtrValid
            && ((txPagePointer <= `PTR_LOW_BAD)
            || (txPagePointer > pageLimit));
        setVec[`EVT_NO_REPLY] = bufferQueryNoReply;
        setVec[`EVT_TX_ERR] = bufferQueryNoReply || txFailed;
    end

    // Clear requests; zeros written leave bits alone
    always_comb begin
        clrVec = wrOnes & `EVT_RW_MASK;
        if (cmdSend) begin
            clrVec = clrVec | `EVT_SEND_CLR;
        end
        if (cmdWarnClr) begin
            clrVec = `EVT_RW_MASK;
        end
    end

    // Next-state logic for the whole block
    always_comb begin
        n = s;
        n.pageClr = 1'b0;
        // Free-running time; host writes never reach it
        if (timeTick) begin
            n.netTime = s.netTime + 16'h0001;
        end
        // A set arriving with a clear wins, so only a soft reset loses an event
        n.flags = ((s.flags & ~clrVec) | setVec) & `EVT_RW_MASK;
        // Error detail captured with the flag
        if (rxAbort && rxIsPacket) begin
            n.detail[7:5] = rxErrCode;
            n.detail[4:0] = rxSenderId;
        end
        if (decodeCorrected) begin
            n.detail[11:8] = decodeInfo;
        end
        // Sync state: master node always reads locked
        if (timeMasterNode || syncLock) begin
            n.unlocked = 1'b0;
        end else if (syncLost) begin
            n.unlocked = 1'b1;
        end
        // Warning timer runs while remote pages wait for data
        if (cmdWarnClr || remoteRxData || !remotePagesActive) begin
            n.warnCnt = 32'h00000000;
        end else if (s.warnCnt >= 32'(WARN_CYC) - 32'h00000001) begin
            n.warnFlag = 1'b1;
        end else begin
            n.warnCnt = s.warnCnt + 32'h00000001;
        end
        if (cmdWarnClr) begin
            n.warnFlag = 1'b0;
            n.pageClr = 1'b1;
        end
        n.coreIrq = coreInterrupt;
        n.txAvail = transmitterAvailable;
        // Host reads; 8-bit hosts get bytes in the low lane
        if (busRd) begin
            case (busAddr)
                `NES_ADDR_TIME_LO: begin
                    if (wideBus) begin
                        n.rdData = s.netTime;
                    end else begin
                        // Hold the high byte for the second read
                        n.rdData = {8'h00, s.netTime[7:0]};
                        n.timeHold = s.netTime[15:8];
                    end
                end
                `NES_ADDR_TIME_HI: begin
                    n.rdData = {8'h00, s.timeHold};
                end
                `NES_ADDR_EVT_LO: begin
                    n.rdData = wideBus ? statusNow
                        : {8'h00, statusNow[7:0]};
                end
                `NES_ADDR_EVT_HI: begin
                    n.rdData = {8'h00, statusNow[15:8]};
                end
                default: begin
                    n.rdData = 16'h0000;
                end
            endcase
        end
        // Soft reset clears flags and forces the unlocked state except on the master node
        if (softReset) begin
            n.flags = 16'h0000;
            n.unlocked = !timeMasterNode;
            n.warnFlag = 1'b0;
            n.warnCnt = 32'h00000000;
        end
        // Interrupt follows the next status so it lines up with reads
        n.irq = |(status_word(n) & eventMask);
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s.netTime <= `TIME_RESET;
            s.timeHold <= 8'h00;
            s.flags <= 16'h0000;
            s.unlocked <= 1'b1;
            s.warnFlag <= 1'b0;
            s.warnCnt <= 32'h00000000;
            s.coreIrq <= 1'b0;
            s.txAvail <= 1'b1;
            s.detail <= `DETAIL_RESET;
            s.rdData <= 16'h0000;
            s.irq <= 1'b0;
            s.pageClr <= 1'b0;
        end else begin
            s <= n;
        end
    end

    assign busRdData = s.rdData;
    assign irq = s.irq;
    assign errorDetail = s.detail;
    assign remotePageClr = s.pageClr;

    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    AST_TIME_COUNT: assert property (
        timeTick |=> s.netTime == $past(s.netTime) + 16'h0001)
        else $error("time counter did not advance");
    AST_BYTE_LATCH: assert property (
        (busRd && !wideBus && busAddr == `NES_ADDR_TIME_LO)
        ##1 (busRd && !wideBus && busAddr == `NES_ADDR_TIME_HI)
        |=> busRdData[7:0] == $past(s.netTime[15:8], 2))
        else $error("high time byte not coherent");
    AST_RECEIVE_ERROR_FLAG_SET: assert property (
        rxAbort && rxIsPacket && !softReset
        |=> s.flags[`EVT_RX_ERR] && errorDetail[4:0] == $past(rxSenderId))
        else $error("receive error not captured");
    AST_RECEIVE_ERROR_FLAG_NONPKT: assert property (
        !s.flags[`EVT_RX_ERR] && !(rxAbort && rxIsPacket)
        |=> !s.flags[`EVT_RX_ERR])
        else $error("receive error set by non-packet");
    AST_W1C_OWN: assert property (
        wrEvtLo && wideBus && busWrData[`EVT_OWN_RX] && !ownDone
        |=> !s.flags[`EVT_OWN_RX])
        else $error("write one did not clear flag");
    AST_ZERO_WRITE: assert property (
        s.flags[`EVT_OWN_RX] && wrEvtLo && wideBus
        && !busWrData[`EVT_OWN_RX] && !softReset && !cmdWarnClr
        |=> s.flags[`EVT_OWN_RX])
        else $error("zero write cleared flag");
    AST_MASTER_LOCK: assert property (
        timeMasterNode[*2] |-> !s.unlocked)
        else $error("master node reports unlocked");
    AST_WARN_STICKY: assert property (
        s.warnFlag && !cmdWarnClr && !softReset |=> s.warnFlag)
        else $error("warning flag dropped without clear");
    AST_SEND_CLR: assert property (
        cmdSend && !txFailed && !bufferQueryNoReply && !softReset
        |=> !statusNow[2] && !statusNow[1])
        else $error("send command left transmit errors");
    AST_NOREPLY_PAIR: assert property (
        bufferQueryNoReply && !softReset |=> statusNow[2:1] == 2'b11)
        else $error("no-reply did not set both bits");
    AST_IRQ_MASK: assert property (
        !$past(rst) |-> irq == |(statusNow & $past(eventMask)))
        else $error("interrupt disagrees with status and mask");
endmodule

// ---- tb/nes_host_model.sv ----
// Host processor model: byte and word cycles on the status register bus
`timescale 1ns/10ps
module nes_host_model (
    input wire logic sys_clk,
    output logic wideBus,
    output logic [7:0] busAddr,
    output logic busRd,
    output logic busWr,
    output logic [15:0] busWrData,
    input wire logic [15:0] busRdData
);
    // Idle bus; address and data carry junk, never a stale request
    initial begin
        wideBus = 1'b1;
        busAddr = 8'h5a;
        busRd = 1'b0;
        busWr = 1'b0;
        busWrData = 16'ha5a5;
    end

    // One strobe, held to the taking edge, then released and scrambled
    task automatic cyc(input logic rd, input logic [7:0] a,
                       input logic [15:0] d, input logic w);
        @(posedge sys_clk);
        #1;
        wideBus = w;
        busAddr = a;
        busWrData = d;
        busRd = rd;
        busWr = ~rd;
        @(posedge sys_clk);
        #1;
        busRd = 1'b0;
        busWr = 1'b0;
        busAddr = ~busAddr;
        busWrData = ~busWrData;
    endtask

    // Read; data stands until the next read, so one spare edge is safe
    task automatic rd(input logic [7:0] a, input logic w,
                      output logic [15:0] d);
        cyc(1'b1, a, 16'h0000, w);
        @(posedge sys_clk);
        #1;
        d = busRdData;
    endtask

    // Write of one byte or word
    task automatic wr(input logic [7:0] a, input logic w,
                      input logic [15:0] d);
        cyc(1'b0, a, d, w);
    endtask

    // Back-to-back low then high time byte reads of an 8-bit host
    task automatic rdPair(output logic [15:0] lo, output logic [15:0] hi);
        @(posedge sys_clk);
        #1;
        wideBus = 1'b0;
        busAddr = 8'h10;
        busRd = 1'b1;
        @(posedge sys_clk);
        #1;
        busAddr = 8'h11;
        lo = busRdData;
        @(posedge sys_clk);
        #1;
        busRd = 1'b0;
        hi = busRdData;
    endtask
endmodule

// ---- tb/network_event_status_test.sv ----
// Self-checking bench for the network time counter and event status
`timescale 1ns/10ps
module network_event_status_test;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic cmdValid = 1'b0;
    logic [7:0] cmdCode = 8'h00;
    logic [15:0] eventMask = 16'h0000;
    logic [4:0] sourceIdSelect = 5'h00;
    logic timeMasterNode = 1'b0;
    logic rxIsPacket = 1'b0;
    logic [2:0] rxErrCode = 3'h0;
    logic [4:0] rxSenderId = 5'h00;
    logic [3:0] decodeInfo = 4'h0;
    logic remotePagesActive = 1'b0;
    logic [4:0] rxSrcId = 5'h00;
    logic hubTxActive = 1'b0;
    logic hubEnabled = 1'b1;
    logic rate5M = 1'b0;
    logic [7:0] txPagePointer = 8'h03;
    logic [7:0] pageLimit = 8'h80;
    logic coreInterrupt = 1'b0;
    logic transmitterAvailable = 1'b1;
    // Event pulses, one bit each; the flag events sit at their status bits
    logic [15:0] ev = 16'h0000;
    logic [31:0] seed = 32'h8390;
    logic [15:0] d, hiByte;
    wire logic wideBus, busRd, busWr, irq, remotePageClr, hubReset;
    wire logic decoderReset;
    wire logic [7:0] busAddr;
    wire logic [15:0] busWrData, busRdData, errorDetail;
    int bad_count = 0;
    int tests_run = 0;
    int hubCnt = 0;
    int decCnt = 0;
    int mdl = 16'h2001; // Expected status word
    int k;
    int m;
    int fl[11] = '{15, 14, 11, 10, 9, 8, 7, 6, 4, 2, 1};

    // Short counts keep the watchdog and warning runs brief
    network_event_status #(.HUB_SLOW_CYC(20), .HUB_FAST_CYC(10),
        .WARN_CYC(50)) uut (
        .sys_clk(sys_clk), .rst(rst), .softReset(ev[5]),
        .wideBus(wideBus), .busAddr(busAddr), .busRd(busRd),
        .busWr(busWr), .busWrData(busWrData), .cmdValid(cmdValid),
        .cmdCode(cmdCode), .eventMask(eventMask),
        .sourceIdSelect(sourceIdSelect), .timeTick(ev[3]),
        .syncLock(ev[0]), .syncLost(ev[13]),
        .timeMasterNode(timeMasterNode), .rxAbort(ev[15]),
        .rxIsPacket(rxIsPacket), .rxErrCode(rxErrCode),
        .rxSenderId(rxSenderId), .decodeCorrected(ev[14]),
        .decodeInfo(decodeInfo), .remotePagesActive(remotePagesActive),
        .remoteRxData(ev[12]), .freeformDone(ev[11]),
        .remoteDone(ev[10]), .ownDone(ev[9]), .rxSrcValid(ev[8]),
        .rxSrcId(rxSrcId), .tokenRetry(ev[7]), .replyRepair(ev[6]),
        .hubTxActive(hubTxActive), .hubEnabled(hubEnabled),
        .rate5M(rate5M), .txPtrValid(ev[4]),
        .txPagePointer(txPagePointer), .pageLimit(pageLimit),
        .coreInterrupt(coreInterrupt), .bufferQueryNoReply(ev[2]),
        .txFailed(ev[1]), .transmitterAvailable(transmitterAvailable),
        .busRdData(busRdData), .irq(irq), .errorDetail(errorDetail),
        .remotePageClr(remotePageClr), .hubReset(hubReset),
        .decoderReset(decoderReset));

    nes_host_model host (.sys_clk(sys_clk), .wideBus(wideBus),
        .busAddr(busAddr), .busRd(busRd), .busWr(busWr),
        .busWrData(busWrData), .busRdData(busRdData));

    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    // Count reset pulses on the falling edge, clear of the update edge
    always @(negedge sys_clk) begin
        if (hubReset === 1'b1) hubCnt++;
        if (decoderReset === 1'b1) decCnt++;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic clk(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // One-cycle pulse on an event line
    task automatic pulse(input int b);
        clk(1);
        ev[b] = 1'b1;
        clk(1);
        ev[b] = 1'b0;
    endtask

    // Word read of the status register against the model
    task automatic stat(input string n);
        host.rd(8'h12, 1'b1, d);
        chk(n, mdl[15:0], d);
    endtask

    // Command pulse; the page clear follows the warning clear only
    task automatic cmd(input logic [7:0] c);
        clk(1);
        cmdCode = c;
        cmdValid = 1'b1;
        clk(1);
        cmdValid = 1'b0;
        chk("pageClr", {15'h0, c == 8'h0a}, {15'h0, remotePageClr});
    endtask

    task automatic done(input string n);
        $display("test %s finished", n);
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Hang guard, well beyond the roughly 1550 cycles the tests need
    initial begin
        #100000;
        bad_count++;
        end_sim();
    end

    initial begin
        clk(5);
        rst = 1'b0;
        stat("resetStat");
        chk("resetIrq", 16'h0, {15'h0, irq});
        // Time counter: random count, then a byte pair across a carry
        k = seed[7:0];
        repeat (k) pulse(3);
        host.rd(8'h10, 1'b1, d);
        chk("time", k[15:0], d);
        repeat (255 - k) pulse(3);
        host.rd(8'h10, 1'b0, d);
        chk("timeLo", 16'h00ff, d);
        pulse(3);
        host.rd(8'h11, 1'b0, d);
        chk("timeHi", 16'h0000, d);
        host.wr(8'h10, 1'b1, 16'h1234);
        host.rd(8'h10, 1'b1, d);
        chk("timeRo", 16'h0100, d);
        // Back-to-back byte pair with the carry between the two reads
        repeat (254) pulse(3);
        clk(1);
        ev[3] = 1'b1;
        host.rdPair(d, hiByte);
        ev[3] = 1'b0;
        chk("pairLo", 16'h00ff, d);
        chk("pairHi", 16'h0001, hiByte);
        done("time");
        // Events that must not set anything
        seed = lfsr(seed);
        sourceIdSelect = seed[4:0];
        rxSrcId = ~seed[4:0];
        pulse(15);
        pulse(4);
        pulse(8);
        stat("noSet");
        // Each writable flag but bit 5: set, interrupt, zero write, one write
        rxIsPacket = 1'b1;
        rxSrcId = sourceIdSelect;
        txPagePointer = 8'h02;
        foreach (fl[i]) begin
            m = (fl[i] == 2) ? 6 : 1 << fl[i];
            seed = lfsr(seed);
            rxErrCode = seed[7:5];
            rxSenderId = seed[4:0];
            decodeInfo = seed[11:8];
            eventMask = 16'(1 << fl[i]);
            pulse(fl[i]);
            mdl |= m;
            stat("flagSet");
            chk("irqOn", 16'h1, {15'h0, irq});
            if (fl[i] == 15) begin
                chk("rxDet", 16'(seed[7:0]), 16'(errorDetail[7:0]));
            end
            if (fl[i] == 14) begin
                chk("decDet", 16'(seed[11:8]), 16'(errorDetail[11:8]));
            end
            host.wr(8'h12, 1'b1, 16'h0000);
            stat("zeroWr");
            host.wr(8'h12, 1'b1, m[15:0]);
            mdl &= ~m;
            stat("flagClr");
            chk("irqOff", 16'h0, {15'h0, irq});
        end
        done("flags");
        // Pointer at the page end is legal, one past it is not
        txPagePointer = pageLimit;
        pulse(4);
        stat("ptrEnd");
        txPagePointer = pageLimit + 8'h01;
        pulse(4);
        mdl |= 16;
        stat("ptrHigh");
        host.wr(8'h12, 1'b1, 16'h0010);
        mdl &= ~16;
        // Transmit outcome bits and commands
        pulse(2);
        mdl |= 6;
        cmd(8'h03);
        mdl &= ~6;
        stat("sendClr");
        transmitterAvailable = 1'b0;
        coreInterrupt = 1'b1;
        mdl = 16'h2008;
        stat("txBusy");
        transmitterAvailable = 1'b1;
        coreInterrupt = 1'b0;
        pulse(11);
        pulse(7);
        mdl = 16'h2881;
        host.rd(8'h13, 1'b0, d);
        chk("statHi", {8'h0, mdl[15:8]}, d);
        cmd(8'h0a);
        mdl = 16'h2001;
        stat("warnCmd");
        done("transmit");
        // Warning timer: restarted by data, then left to run out
        remotePagesActive = 1'b1;
        repeat (4) begin
            clk(30);
            pulse(12);
        end
        stat("warnRestart");
        clk(60);
        mdl |= 16'h1000;
        stat("warnSet");
        host.wr(8'h12, 1'b1, 16'h1000);
        stat("warnRo");
        cmd(8'h0a);
        mdl &= ~16'h1000;
        stat("warnClr");
        remotePagesActive = 1'b0;
        done("warning");
        // Hub watchdog at both rates, decoders spared when hub is off
        hubTxActive = 1'b1;
        clk(15);
        hubTxActive = 1'b0;
        stat("hubShort");
        hubTxActive = 1'b1;
        clk(30);
        hubTxActive = 1'b0;
        mdl |= 32;
        stat("hubSlow");
        chk("hubRst", 16'h1, hubCnt[15:0]);
        chk("decRst", 16'h1, decCnt[15:0]);
        host.wr(8'h12, 1'b1, 16'h0020);
        rate5M = 1'b1;
        hubEnabled = 1'b0;
        hubTxActive = 1'b1;
        clk(15);
        hubTxActive = 1'b0;
        stat("hubFast");
        chk("hubRstOff", 16'h2, hubCnt[15:0]);
        chk("decRstOff", 16'h1, decCnt[15:0]);
        done("hub");
        // Time lock, loss and the software reset
        pulse(0);
        mdl &= ~16'h2000;
        stat("lock");
        pulse(13);
        mdl |= 16'h2000;
        stat("lost");
        pulse(0);
        pulse(9);
        pulse(5);
        mdl = 16'h2001;
        stat("soft");
        timeMasterNode = 1'b1;
        pulse(5);
        mdl = 16'h0001;
        stat("master");
        done("sync");
        end_sim();
    end
endmodule
